// ---- programmable_watchdog_timer_bench.sv ----
// Self-checking bench for the programmable watchdog top level
`timescale 1ns/100ps
`default_nettype none
module programmable_watchdog_timer_bench;
  import pwd_pkg::*;
  // ----------------------------------------------------------------
  // Clock, reset and ports
  // ----------------------------------------------------------------
  localparam int unsigned TWS = 4;
  logic         core_clk    = 1'b0;
  logic         rstn        = 1'b0;
  pwd_bus_req_t bus_req     = '0;
  logic         idle_mode   = 1'b0;
  logic         power_down  = 1'b0;
  logic [7:0]   rdata;
  logic         cpu_reset;
  logic         running;
  logic         irq;
  int           err_total   = 0;
  int           check_count = 0;
  logic [7:0]   exp_q[$];
  logic         rd_due;
  logic [7:0]   bad;

  // Free-running 125 MHz clock
  always #4 core_clk = ~core_clk;

  pwd_watchdog_top #(.TW(TWS), .PW(PRESC_W)) i_dut (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .bus_req    (bus_req),
    .rdata      (rdata),
    .idle_mode  (idle_mode),
    .power_down (power_down),
    .cpu_reset  (cpu_reset),
    .running    (running),
    .irq        (irq)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One bus cycle, launched just after a rising edge
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask

  // Note the expected data, then issue the read
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, 8'h00);
  endtask

  task automatic idle();
    op(1'b0, 1'b0, 8'h00, 8'h00);
  endtask

  task automatic keys();
    wr(ADDR_SERVICE, KEY_FIRST);
    wr(ADDR_SERVICE, KEY_SECOND);
    idle();
  endtask

  // Count edges until the reset pulse, bounded
  task automatic wait_reset(input logic [15:0] exp);
    logic [15:0] n;
    n = '0;
    #1;
    while (cpu_reset !== 1'b1) begin
      if (n > 16'd5000) begin
        err_total++;
        stop_test();
      end
      @(posedge core_clk);
      #1;
      n++;
    end
    check("reset delay", n, exp);
    check("running off", running, 16'h0);
  endtask

  // Read monitor: data stands in the cycle after the taking edge
  always @(posedge core_clk) begin
    rd_due = bus_req.rd;
    if (rd_due) begin
      #1;
      if (exp_q.size() == 0) begin
        err_total++;
        $display("wrong value read queue expected 1 seen 0");
      end else begin
        check("read data", rdata, exp_q.pop_front());
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(24427));
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);

    rd(ADDR_CONTROL, CTRL_RESET);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_MASK, 8'h00);
    rd(ADDR_SERVICE, READ_IDLE);
    rd(8'h10, READ_IDLE);
    wr(ADDR_CONTROL, 8'h01);
    rd(ADDR_CONTROL, 8'h00);
    idle();
    #1 check("running idle", running, 16'h0);
    $display("test reset values done");

    // period code sweep with masked interrupt
    for (int c = 0; c < 8; c++) begin
      wr(ADDR_CONTROL, 8'(c << CTRL_PS_LSB));
      keys();
      #1 check("running on", running, 16'h1);
      wait_reset(16'(1 << (TWS + c)));
      rd(ADDR_CONTROL, 8'(c << CTRL_PS_LSB) | 8'h02);
      rd(ADDR_STATUS, 8'h01);
      rd(ADDR_STATUS, 8'h00);
      #1 check("irq masked", irq, 16'h0);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_CONTROL, 8'h00);
    end
    $display("test timeout periods done");

    // service with a read between keys
    wr(ADDR_CONTROL, 8'h00);
    keys();
    // Second key must land before the 16-cycle period runs out
    repeat (3 + $urandom % 9) @(posedge core_clk);
    wr(ADDR_SERVICE, KEY_FIRST);
    rd(ADDR_CONTROL, 8'h01);
    wr(ADDR_SERVICE, KEY_SECOND);
    idle();
    wait_reset(16'(1 << TWS));
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    $display("test service done");

    // wrong value, wrong order, intervening write
    wr(ADDR_MASK, 8'h03);
    for (int b = 0; b < 4; b++) begin
      bad = 8'($urandom);
      if (bad == KEY_FIRST || bad == KEY_SECOND) begin
        bad = 8'h55;
      end
      case (b)
        0: wr(ADDR_SERVICE, bad);
        1: wr(ADDR_SERVICE, KEY_SECOND);
        2: begin
          wr(ADDR_SERVICE, KEY_FIRST);
          wr(ADDR_SERVICE, KEY_FIRST);
        end
        default: begin
          wr(ADDR_SERVICE, KEY_FIRST);
          wr(8'h10, 8'h00);
        end
      endcase
      idle();
      wait_reset(16'h0);
      @(posedge core_clk);
      #1 check("irq raised", irq, 16'h1);
      rd(ADDR_CONTROL, 8'h02);
      rd(ADDR_STATUS, 8'h02);
      wr(ADDR_CONTROL, 8'h00);
      idle();
      @(posedge core_clk);
      #1 check("irq cleared", irq, 16'h0);
    end
    $display("test bad sequences done");

    // idle freeze, idle run, power-down stop
    for (int m = 0; m < 3; m++) begin
      wr(ADDR_CONTROL, (m == 0) ? 8'h50 : 8'h40);
      keys();
      idle_mode  <= (m < 2);
      power_down <= (m == 2);
      repeat (20) @(posedge core_clk);
      idle_mode  <= 1'b0;
      power_down <= 1'b0;
      wait_reset((m == 1) ? 16'd44 : 16'd64);
      wr(ADDR_CONTROL, 8'h00);
    end
    $display("test power states done");

    keys();
    #1 check("running before reset", running, 16'h1);
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge core_clk);
    #1 check("running after reset", running, 16'h0);
    rd(ADDR_CONTROL, CTRL_RESET);
    idle();
    idle();
    check("reads left unseen", 16'(exp_q.size()), 16'h0);
    $display("test system reset done");
    stop_test();
  end
endmodule // programmable_watchdog_timer_bench
`default_nettype wire

// ---- pwd_count_chain.sv ----
// Prescaler and timer chain that marks the watchdog timeout
`timescale 1ns/100ps
`default_nettype none
module pwd_count_chain
  import pwd_pkg::*;
#(
  parameter int unsigned TW = TIMER_W,
  parameter int unsigned PW = PRESC_W
) (
  // Clock and reset
  input  wire logic            core_clk,
  input  wire logic            rstn_sync,
  // Control
  input  wire logic            clear,
  input  wire logic            advance,
  input  wire logic [PS_W-1:0] period_sel,
  // Results
  output logic                 expire,
  output logic [TW+PW-1:0]     count_value
);

  if (PW < (1 << PS_W) - 1) begin : g_check
    $error("prescaler too narrow for the period select range");
  end

  typedef struct packed {
    logic [PW-1:0] presc;
    logic [TW-1:0] timer;
  } pwd_chain_state_t;

  pwd_chain_state_t state;
  pwd_chain_state_t next_state;
  logic [PW-1:0]    presc_mask;
  logic             presc_last;
  logic             tick;

  always_comb begin
    presc_mask  = PW'((32'h1 << period_sel) - 32'h1);
    presc_last  = &(state.presc | ~presc_mask);
    tick        = advance && presc_last;
    expire      = tick && (&state.timer);
    next_state  = state;
    if (clear) begin
      next_state = '0;
    end else if (advance) begin
      next_state.presc = presc_last ? '0 : state.presc + PW'(1);
      if (tick) begin
        next_state.timer = state.timer + TW'(1);
      end
    end
  end

  // Chain registers
  always_ff @(posedge core_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign count_value = {state.timer, state.presc};

endmodule // pwd_count_chain
`default_nettype wire

// ---- pwd_pkg.sv ----
// Package for the programmable watchdog: register map, fields, keys and types
`default_nettype none
package pwd_pkg;

  // ----------------------------------------------------------------
  // Counting chain shape
  // ----------------------------------------------------------------
  localparam int unsigned TIMER_W = 14;
  localparam int unsigned PRESC_W = 7;
  localparam int unsigned PS_W    = 3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SERVICE = 8'hA6;
  localparam logic [7:0] ADDR_CONTROL = 8'hA7;
  localparam logic [7:0] ADDR_STATUS  = 8'hA8;
  localparam logic [7:0] ADDR_MASK    = 8'hA9;

  // Service keys
  localparam logic [7:0] KEY_FIRST  = 8'h1E;
  localparam logic [7:0] KEY_SECOND = 8'hE1;

  // ----------------------------------------------------------------
  // Control register fields
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_PS_LSB   = 5;
  localparam int unsigned CTRL_IDLE_BIT = 4;
  localparam int unsigned CTRL_OVF_BIT  = 1;
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [7:0]  READ_IDLE     = 8'h00;

  // Interrupt status and mask fields
  localparam int unsigned INT_W           = 2;
  localparam int unsigned INT_TIMEOUT_BIT = 0;
  localparam int unsigned INT_BADSEQ_BIT  = 1;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pwd_bus_req_t;

  typedef enum logic [0:0] {
    SEQ_IDLE,
    SEQ_ARMED
  } pwd_seq_t;

endpackage
`default_nettype wire

// ---- pwd_reset_sync.sv ----
// Reset release synchroniser for the watchdog clock domain
`timescale 1ns/100ps
`default_nettype none
module pwd_reset_sync
  import pwd_pkg::*;
(
  // Clock and raw reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Synchronised reset
  output logic      rstn_sync
);

  typedef struct packed {
    logic stage1;
    logic stage2;
  } pwd_sync_state_t;

  pwd_sync_state_t state;
  pwd_sync_state_t next_state;

  // Shift a one through two flops after release
  always_comb begin
    next_state.stage1 = 1'b1;
    next_state.stage2 = state.stage1;
  end

  // Assert at once, release on the clock
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rstn_sync = state.stage2;

endmodule // pwd_reset_sync
`default_nettype wire

// ---- pwd_watchdog_top.sv ----
// Programmable watchdog: service sequencer, control registers and reset pulse
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module pwd_watchdog_top
  import pwd_pkg::*;
#(
  parameter int unsigned TW = TIMER_W,
  parameter int unsigned PW = PRESC_W
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         rstn,
  // Register port
  input  wire pwd_bus_req_t bus_req,
  output logic [7:0]        rdata,
  // Power state of the CPU
  input  wire logic         idle_mode,
  input  wire logic         power_down,
  // Results
  output logic              cpu_reset,
  output logic              running,
  output logic              irq
);

  if (TW < 1) begin : g_check_tw
    $error("timer width must be at least one");
  end

  if (PW < (1 << PS_W) - 1) begin : g_check_pw
    $error("prescaler width must cover every period code");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pwd_seq_t         seq;
    logic             enabled;
    logic [PS_W-1:0]  period_sel;
    logic             idle_freeze;
    logic             ovf;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [7:0]       rdata;
    logic             cpu_rst;
    logic             irq;
  } pwd_top_state_t;

  localparam pwd_top_state_t STATE_RESET = '{
    seq:         SEQ_IDLE,
    enabled:     1'b0,
    period_sel:  CTRL_RESET[CTRL_PS_LSB +: PS_W],
    idle_freeze: CTRL_RESET[CTRL_IDLE_BIT],
    ovf:         CTRL_RESET[CTRL_OVF_BIT],
    int_status:  '0,
    int_mask:    '0,
    rdata:       READ_IDLE,
    cpu_rst:     1'b0,
    irq:         1'b0
  };

  pwd_top_state_t      state;
  pwd_top_state_t      next_state;
  logic                rstn_sync;
  logic                svc_wr;
  logic                other_wr;
  logic                ctrl_wr;
  logic                good_first;
  logic                good_second;
  logic                bad_seq;
  logic                advance;
  logic                expire;
  logic                trip;
  logic                chain_clear;
  logic [TW+PW-1:0]    count_value;
  logic [7:0]          ctrl_view;

  // Write to a given register this cycle
  function automatic logic write_to(input pwd_bus_req_t req, input logic [7:0] addr);
    return req.wr && (req.addr == addr);
  endfunction

  // Read of a given register this cycle
  function automatic logic read_of(input pwd_bus_req_t req, input logic [7:0] addr);
    return req.rd && (req.addr == addr);
  endfunction

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  pwd_reset_sync u_reset_sync (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .rstn_sync (rstn_sync)
  );

  pwd_count_chain #(
    .TW (TW),
    .PW (PW)
  ) u_chain (
    .core_clk    (core_clk),
    .rstn_sync   (rstn_sync),
    .clear       (chain_clear),
    .advance     (advance),
    .period_sel  (state.period_sel),
    .expire      (expire),
    .count_value (count_value)
  );

  // ----------------------------------------------------------------
  // Sequence decode
  // ----------------------------------------------------------------
  // two consecutive service writes form a key pair
  always_comb begin
    svc_wr      = write_to(bus_req, ADDR_SERVICE);
    other_wr    = bus_req.wr && (bus_req.addr != ADDR_SERVICE);
    ctrl_wr     = write_to(bus_req, ADDR_CONTROL);
    good_first  = (state.seq == SEQ_IDLE) && svc_wr && (bus_req.wdata == KEY_FIRST);
    good_second = (state.seq == SEQ_ARMED) && svc_wr && (bus_req.wdata == KEY_SECOND);
    // wrong key, wrong order or a write in between
    bad_seq     = (svc_wr && !good_first && !good_second)
                  || ((state.seq == SEQ_ARMED) && other_wr);
  end

  // Counting gate and reset cause
  always_comb begin
    // run unless off, powered down or frozen in idle
    advance     = state.enabled && !power_down && !(idle_mode && state.idle_freeze);
    // expiry or bad sequence trips the reset
    trip        = expire || bad_seq;
    chain_clear = good_second || trip || !state.enabled;
  end

  // Control register as software sees it
  always_comb begin
    ctrl_view = '0;
    ctrl_view[CTRL_PS_LSB +: PS_W] = state.period_sel;
    ctrl_view[CTRL_IDLE_BIT]       = state.idle_freeze;
    ctrl_view[CTRL_OVF_BIT]        = state.ovf;
    ctrl_view[CTRL_RUN_BIT]        = state.enabled;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;

    // Key sequencer
    case (state.seq)
      SEQ_IDLE: begin
        if (good_first && !trip) begin
          next_state.seq = SEQ_ARMED;
        end
      end
      SEQ_ARMED: begin
        if (good_second || trip) begin
          next_state.seq = SEQ_IDLE;
        end
      end
      default: begin
        next_state.seq = SEQ_IDLE;
      end
    endcase

    // enable on keys, drop on own reset
    if (trip) begin
      next_state.enabled = 1'b0;
    end else if (good_second) begin
      next_state.enabled = 1'b1;
    end

    // one-cycle reset pulse to the CPU
    next_state.cpu_rst = trip;

    // Control writes; running bit is not writable
    if (ctrl_wr) begin
      next_state.period_sel  = bus_req.wdata[CTRL_PS_LSB +: PS_W];
      next_state.idle_freeze = bus_req.wdata[CTRL_IDLE_BIT];
    end

    // sticky flag, set beats a zero write
    next_state.ovf = trip || (state.ovf && !(ctrl_wr && !bus_req.wdata[CTRL_OVF_BIT]));

    // Event status, cleared by reading it, set wins
    if (read_of(bus_req, ADDR_STATUS)) begin
      next_state.int_status = '0;
    end
    if (expire) begin
      next_state.int_status[INT_TIMEOUT_BIT] = 1'b1;
    end
    if (bad_seq) begin
      next_state.int_status[INT_BADSEQ_BIT] = 1'b1;
    end

    // Interrupt mask
    if (write_to(bus_req, ADDR_MASK)) begin
      next_state.int_mask = bus_req.wdata[INT_W-1:0];
    end
    next_state.irq = |(next_state.int_status & next_state.int_mask);

    // read data for one cycle; service port reads zero
    next_state.rdata = READ_IDLE;
    if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CONTROL: next_state.rdata = ctrl_view;
        ADDR_STATUS:  next_state.rdata = 8'(state.int_status);
        ADDR_MASK:    next_state.rdata = 8'(state.int_mask);
        default:      next_state.rdata = READ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // system reset leaves the watchdog off
  always_ff @(posedge core_clk or negedge rstn_sync) begin
    if (!rstn_sync) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign rdata     = state.rdata;
  assign cpu_reset = state.cpu_rst;
  assign running   = state.enabled;
  assign irq       = state.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn_sync);

  // enable after a good key pair
  key_enable_a: assert property (
    good_second && !expire |=> running && cpu_reset == 1'b0)
    else $error("good key pair did not enable the watchdog");

  run_readback_a: assert property (
    bus_req.rd && bus_req.addr == ADDR_CONTROL
    |=> rdata[CTRL_RUN_BIT] == $past(state.enabled))
    else $error("running bit does not follow enable");

  // timeout pulses reset for one cycle
  timeout_pulse_a: assert property (
    expire |=> cpu_reset ##1 !cpu_reset)
    else $error("timeout did not give a one-cycle reset");

  bad_key_a: assert property (
    svc_wr && state.seq == SEQ_IDLE && bus_req.wdata != KEY_FIRST |=> cpu_reset && !running)
    else $error("wrong key did not reset immediately");

  // reads between keys keep the sequence
  read_between_a: assert property (
    state.seq == SEQ_ARMED && !bus_req.wr && !expire |=> state.seq == SEQ_ARMED)
    else $error("read broke the key sequence");

  // foreign write between keys breaks it
  write_between_a: assert property (
    state.seq == SEQ_ARMED && other_wr |=> cpu_reset && state.seq == SEQ_IDLE)
    else $error("intervening write did not break the sequence");

  // flag set by every watchdog reset
  flag_set_a: assert property (
    trip |=> state.ovf && cpu_reset)
    else $error("overflow flag not set by watchdog reset");

  // flag holds until a zero write
  flag_hold_a: assert property (
    state.ovf && !(ctrl_wr && !bus_req.wdata[CTRL_OVF_BIT]) |=> state.ovf)
    else $error("overflow flag cleared without software");

  idle_freeze_a: assert property (
    state.idle_freeze && idle_mode && !chain_clear |=> $stable(count_value))
    else $error("count moved while frozen in idle");

  pdown_hold_a: assert property (
    power_down && !chain_clear |=> $stable(count_value))
    else $error("count moved in power-down");

  count_step_a: assert property (
    advance && !chain_clear |=> count_value != $past(count_value))
    else $error("running count did not advance");

  service_clear_a: assert property (
    good_second |=> count_value == '0)
    else $error("service did not clear the chain");

  service_read_a: assert property (
    bus_req.rd && bus_req.addr == ADDR_SERVICE |=> rdata == READ_IDLE)
    else $error("service port returned data");

  // own reset leaves the watchdog off
  trip_disable_a: assert property (
    trip |=> !running)
    else $error("watchdog still running after its own reset");

  chain_off_a: assert property (
    !running |=> count_value == '0)
    else $error("chain moved while the watchdog was off");

  // control write cannot touch running bit
  run_readonly_a: assert property (
    ctrl_wr && !trip |=> running == $past(running))
    else $error("control write changed the running bit");

  first_key_a: assert property (
    good_first && !expire |=> state.seq == SEQ_ARMED)
    else $error("first key did not arm the sequence");

  // status read clears the event bits
  status_clear_a: assert property (
    bus_req.rd && bus_req.addr == ADDR_STATUS && !trip |=> state.int_status == '0)
    else $error("status read did not clear the events");

  // power-down freezes but keeps the enable
  pdown_keep_a: assert property (
    power_down && running && !trip |=> running)
    else $error("power-down dropped the enable");

  // Main scenarios
  enable_seen_c: cover property (good_first ##[1:4] good_second);
  timeout_seen_c: cover property (running && expire);
  service_seen_c: cover property (running && good_second);
  bad_seq_seen_c: cover property (state.seq == SEQ_ARMED && other_wr);
  irq_seen_c: cover property (irq && cpu_reset);

endmodule // pwd_watchdog_top
`default_nettype wire
